// >>> core/dcc_pkg.sv
// Constants and types shared by the dual channel counter and PWM unit
//Contract
// RL1 - Classic settings act only in classic mode
// RL2 - Dedup: one event per trigger until lock-reset
// RL3 - Reset-at-reference clears counter instead of reaching
// RL4 - Direction bit: 0 up, 1 down, pulse modes
// RL5 - Edge select: one inverted-chosen edge or both
// RL6 - Channel 1 compares against both references
// RL7 - Dedup applies separately to each comparison
// RL8 - Software avoids second reference with PWM 2
// RL9 - Single codes: pulse, period, width, PWM
// RL10 - Dual codes: trigger, reset, gate, direction
// RL11 - Dual codes: edge timing, encoder x1/x2/x4
// RL12 - Dual mode: both inputs drive counter 1
// RL13 - PWM settings act only in PWM mode
// RL14 - Speed bit: 0 low range, 1 high
// RL15 - Activation pulse precedes PWM on switch-on
// RL16 - Antivalent gating: opposite phase or same idle
// RL17 - Software sets dual-output with antivalent gating
// RL18 - Dual-output drives channel 1 source on both
// RL19 - Inversion applies to input and output
// RL20 - 32-bit counters, one clock, sync reset
// RL21 - All configuration fields reset to zero
package dcc_pkg;
  localparam int CNT_W = 32;
  localparam int CLK_FREQ_MHZ = 25;
  // Tick periods of the PWM time base, in ns
  localparam int PWM_HS_TICK_NS = 125;
  localparam int PWM_LS_TICK_NS = 16000;
  localparam int PWM_HS_TICK_CYC = (PWM_HS_TICK_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int PWM_LS_TICK_CYC = (PWM_LS_TICK_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int TICK_W = 9;
  localparam int ACT_PULSE_TICKS = 1024;
  // Primary function codes that select the counter
  localparam logic [2:0] PRIM_CNT_CLASSIC = 3'h6;
  localparam logic [2:0] PRIM_CNT_PWM = 3'h7;

  typedef enum logic [2:0] {
    FN_PULSE = 3'h0,
    FN_PERIOD = 3'h1,
    FN_WIDTH = 3'h2,
    FN_PWM = 3'h3
  } dcc_single_fn_t;

  typedef enum logic [2:0] {
    FN_TRIG = 3'h0,
    FN_RESET = 3'h1,
    FN_GATE = 3'h2,
    FN_DIRSIG = 3'h3,
    FN_EDGE_TIME = 3'h4,
    FN_ENC_X1 = 3'h5,
    FN_ENC_X2 = 3'h6,
    FN_ENC_X4 = 3'h7
  } dcc_dual_fn_t;

  typedef struct packed {
    logic [2:0] primaryFunctionSelect;
    logic channelInversion;
    logic statusEventDedup;
    logic resetAtReference;
    logic countDirection;
    logic edgeSelect;
    logic [2:0] counterFunctionSelect;
    logic pulseSpeedSelect;
    logic activationPulseEnable;
  } dcc_chan_cfg_t;

  typedef struct packed {
    logic secondReferenceEnable;
    logic dualInputMode;
    logic antivalentGating;
    logic dualOutputDrive;
  } dcc_glob_cfg_t;

  typedef struct packed {
    logic ref2Hit;
    logic ref1Hit;
  } dcc_events_t;

  localparam dcc_chan_cfg_t CHAN_CFG_RESET = '0;
  localparam dcc_glob_cfg_t GLOB_CFG_RESET = '0;
endpackage

// >>> core/dcc_pwm_gen.sv
// PWM generator with tick prescaler and optional activation pulse
`timescale 1ns/1ps
module dcc_pwm_gen #(
  parameter int ACT_TICKS = dcc_pkg::ACT_PULSE_TICKS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic highSpeed,
  input wire logic actPulseEn,
  input wire logic [dcc_pkg::CNT_W-1:0] period,
  input wire logic [dcc_pkg::CNT_W-1:0] duty,
  output logic pwmOut
);
  import dcc_pkg::*;

  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_ACT = 2'b01,
    PS_RUN = 2'b11
  } dcc_pwm_state_t;

  localparam logic [TICK_W-1:0] HS_LAST = TICK_W'(PWM_HS_TICK_CYC - 1);
  localparam logic [TICK_W-1:0] LS_LAST = TICK_W'(PWM_LS_TICK_CYC - 1);
  localparam logic [CNT_W-1:0] ACT_LAST = CNT_W'(ACT_TICKS - 1);

  dcc_pwm_state_t state_ff, nxt_state;
  logic [TICK_W-1:0] pre_ff, nxt_pre;
  logic [CNT_W-1:0] phase_ff, nxt_phase;
  logic pwmOut_ff, nxt_pwmOut;
  logic tick, phaseEnd;

  // Tick length picks the resolution and thus the cycle range [RL14]
  assign tick = (pre_ff == (highSpeed ? HS_LAST : LS_LAST));
  assign nxt_pre = (!enable || tick) ? '0 : pre_ff + 1'b1;
  assign phaseEnd = (state_ff == PS_ACT) ? (phase_ff >= ACT_LAST)
                  : (phase_ff + 1'b1 >= period);

  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    case (state_ff)
      PS_IDLE: begin
        nxt_phase = '0;
        // Long activation pulse before the first regular period [RL15]
        if (enable) nxt_state = actPulseEn ? PS_ACT : PS_RUN;
      end
      PS_ACT: begin
        if (tick) nxt_phase = phaseEnd ? '0 : phase_ff + 1'b1;
        if (tick && phaseEnd) nxt_state = PS_RUN;
      end
      PS_RUN: begin
        if (tick) nxt_phase = phaseEnd ? '0 : phase_ff + 1'b1;
      end
      default: nxt_state = PS_IDLE;
    endcase
    if (!enable) begin
      nxt_state = PS_IDLE;
      nxt_phase = '0;
    end
  end

  assign nxt_pwmOut = (nxt_state == PS_ACT) |
                      ((nxt_state == PS_RUN) && (nxt_phase < duty));

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= PS_IDLE;
      pre_ff <= '0;
      phase_ff <= '0;
      pwmOut_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pre_ff <= nxt_pre;
      phase_ff <= nxt_phase;
      pwmOut_ff <= nxt_pwmOut;
    end
  end

  assign pwmOut = pwmOut_ff;
endmodule

// >>> core/dcc_counter_pwm.sv
// Two channel counter unit: classic counting, compare and PWM outputs
`timescale 1ns/1ps
module dcc_counter_pwm #(
  parameter int ACT_TICKS = dcc_pkg::ACT_PULSE_TICKS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] pinIn,
  input wire logic [1:0] doLevel,
  input wire dcc_pkg::dcc_chan_cfg_t [1:0] chanCfg,
  input wire dcc_pkg::dcc_glob_cfg_t globCfg,
  input wire logic [1:0][dcc_pkg::CNT_W-1:0] refValue,
  input wire logic [1:0][dcc_pkg::CNT_W-1:0] pwmDuty,
  input wire logic lockReset,
  output logic [1:0] pinOut,
  output logic [1:0][dcc_pkg::CNT_W-1:0] countValue,
  output logic [1:0][dcc_pkg::CNT_W-1:0] measValue,
  output dcc_pkg::dcc_events_t [1:0] channelStatusEvents
);
  import dcc_pkg::*;

  dcc_chan_cfg_t [1:0] cfg_ff;
  dcc_glob_cfg_t glob_ff;
  logic [1:0] pinIn_ff, dinPrev_ff, din;
  logic [1:0][CNT_W-1:0] cnt_ff, nxt_cnt, meas_ff, nxt_meas;
  logic [1:0] arm_ff, nxt_arm;
  logic [1:0] lock1_ff, nxt_lock1;
  logic lock2_ff, nxt_lock2;
  dcc_events_t [1:0] evt_ff, nxt_evt;
  logic [1:0] pwmWave, primClassic, primPwm, src;
  logic [1:0] pinOut_ff, nxt_pinOut;
  logic antiOn;

  // Configuration copy; every field clears on reset [RL21]
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_ff <= {CHAN_CFG_RESET, CHAN_CFG_RESET};
      glob_ff <= GLOB_CFG_RESET;
      pinIn_ff <= '0;
      dinPrev_ff <= '0;
    end else begin
      cfg_ff <= chanCfg;
      glob_ff <= globCfg;
      pinIn_ff <= pinIn;
      dinPrev_ff <= din;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : ch
      logic aIn, bIn, aRise, aFall, bRise, bFall, anyA, cntEdge;
      logic active, dual, up, down, clr, latch, dirEff, stepped;
      logic hit1, hit2;
      logic [CNT_W-1:0] stepVal;
      logic [2:0] fn;

      assign primClassic[i] = cfg_ff[i].primaryFunctionSelect
                              == PRIM_CNT_CLASSIC;
      assign primPwm[i] = cfg_ff[i].primaryFunctionSelect == PRIM_CNT_PWM;
      // Input seen by the counters already carries the inversion [RL19]
      assign din[i] = pinIn_ff[i] ^ cfg_ff[i].channelInversion;
      assign aIn = din[i];
      assign bIn = din[1-i];
      assign aRise = aIn & ~dinPrev_ff[i];
      assign aFall = ~aIn & dinPrev_ff[i];
      assign bRise = bIn & ~dinPrev_ff[1-i];
      assign bFall = ~bIn & dinPrev_ff[1-i];
      assign anyA = aRise | aFall;
      // Inversion picks the single polarity; both edges if selected [RL5]
      assign cntEdge = cfg_ff[i].edgeSelect ? anyA : aRise;
      // Counter 2 is folded into counter 1 in dual mode [RL12]
      assign dual = (i == 0) && glob_ff.dualInputMode;
      assign active = primClassic[i] && !((i == 1) && glob_ff.dualInputMode);
      assign fn = cfg_ff[i].counterFunctionSelect;

      always_comb begin
        up = 1'b0;
        down = 1'b0;
        clr = 1'b0;
        latch = 1'b0;
        nxt_arm[i] = arm_ff[i];
        dirEff = cfg_ff[i].countDirection;
        // Classic settings only take effect in classic mode [RL1]
        if (!active) begin
          nxt_arm[i] = 1'b0;
        end else if (!dual) begin
          // Single-mode function decode [RL9]
          case (fn)
            FN_PULSE: begin
              up = cntEdge & ~dirEff;  // [RL4]
              down = cntEdge & dirEff;  // [RL4]
            end
            FN_PERIOD: begin
              latch = aRise;
              clr = aRise;
              up = ~aRise;
            end
            FN_WIDTH: begin
              latch = aFall;
              clr = aFall;
              up = aIn;
            end
            default: ;
          endcase
        end else begin
          // Dual-mode function decode [RL10] [RL11]
          case (fn)
            FN_TRIG: begin
              if (bRise) nxt_arm[i] = 1'b1;
              up = cntEdge & arm_ff[i] & ~dirEff;
              down = cntEdge & arm_ff[i] & dirEff;
            end
            FN_RESET: begin
              clr = bRise;
              up = cntEdge & ~dirEff;
              down = cntEdge & dirEff;
            end
            FN_GATE: begin
              up = cntEdge & bIn & ~dirEff;
              down = cntEdge & bIn & dirEff;
            end
            FN_DIRSIG: begin
              up = cntEdge & ~bIn;
              down = cntEdge & bIn;
            end
            FN_EDGE_TIME: begin
              if (aRise) nxt_arm[i] = 1'b1;
              if (bRise && arm_ff[i]) begin
                nxt_arm[i] = 1'b0;
                latch = 1'b1;
                clr = 1'b1;
              end else begin
                up = arm_ff[i];
              end
            end
            FN_ENC_X1: begin
              up = aRise & ~bIn;
              down = aRise & bIn;
            end
            FN_ENC_X2: begin
              up = (aRise & ~bIn) | (aFall & bIn);
              down = (aRise & bIn) | (aFall & ~bIn);
            end
            FN_ENC_X4: begin
              up = (aRise & ~bIn) | (aFall & bIn)
                 | (bRise & aIn) | (bFall & ~aIn);
              down = (aRise & bIn) | (aFall & ~bIn)
                   | (bRise & ~aIn) | (bFall & aIn);
            end
            default: ;
          endcase
        end
      end

      // Simultaneous up and down still step the counter up, but raise no compare hit
      assign stepped = up ^ down;
      assign stepVal = up ? cnt_ff[i] + 1'b1
                     : down ? cnt_ff[i] - 1'b1 : cnt_ff[i];
      assign hit1 = stepped && !clr && (stepVal == refValue[i]);
      // Second comparison uses the channel 2 reference register [RL6]
      assign hit2 = (i == 0) && glob_ff.secondReferenceEnable && stepped
                    && !clr && (stepVal == refValue[1]);
      // Arriving at the reference clears instead of storing it [RL3]
      assign nxt_cnt[i] = (clr || (cfg_ff[i].resetAtReference && hit1))
                          ? '0 : stepVal;
      assign nxt_meas[i] = latch ? cnt_ff[i] : meas_ff[i];
      // Dedup lock per comparison, set beats the lock reset [RL2] [RL7]
      assign nxt_lock1[i] = cfg_ff[i].statusEventDedup
                            & (hit1 | (lock1_ff[i] & ~lockReset));
      assign nxt_evt[i].ref1Hit = hit1
                                  & ~(cfg_ff[i].statusEventDedup & lock1_ff[i]);
      if (i == 0) begin : second
        assign nxt_lock2 = cfg_ff[0].statusEventDedup
                           & (hit2 | (lock2_ff & ~lockReset));  // [RL7]
        assign nxt_evt[0].ref2Hit = hit2
                                    & ~(cfg_ff[0].statusEventDedup & lock2_ff);
      end else begin : nosecond
        assign nxt_evt[1].ref2Hit = 1'b0;
      end

      // PWM settings only act with the PWM counter selected [RL13]
      dcc_pwm_gen #(
        .ACT_TICKS(ACT_TICKS)
      ) pwm (
        .clk(clk),
        .reset_n(reset_n),
        .enable(primPwm[i]),
        .highSpeed(cfg_ff[i].pulseSpeedSelect),  // [RL14]
        .actPulseEn(cfg_ff[i].activationPulseEnable),  // [RL15]
        .period(refValue[i]),
        .duty(pwmDuty[i]),
        .pwmOut(pwmWave[i])
      );
    end
  endgenerate

  // Counters and flags, one clock, synchronous clear [RL20]
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      meas_ff <= '0;
      arm_ff <= '0;
      lock1_ff <= '0;
      lock2_ff <= 1'b0;
      evt_ff <= '0;
      pinOut_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      meas_ff <= nxt_meas;
      arm_ff <= nxt_arm;
      lock1_ff <= nxt_lock1;
      lock2_ff <= nxt_lock2;
      evt_ff <= nxt_evt;
      pinOut_ff <= nxt_pinOut;
    end
  end

  // Output source per channel; dual drive copies channel 1 [RL18]
  assign src[0] = primPwm[0] ? pwmWave[0] : doLevel[0];
  assign src[1] = glob_ff.dualOutputDrive ? src[0]
                : (primPwm[1] ? pwmWave[1] : doLevel[1]);
  // Antivalent gating relies on dual drive being set by software
  assign antiOn = glob_ff.antivalentGating && glob_ff.dualOutputDrive;
  // Idle level while gated off is shared by both outputs [RL16]
  assign nxt_pinOut = (antiOn && !doLevel[0])
    ? {2{cfg_ff[0].channelInversion ^ cfg_ff[1].channelInversion}}
    : (src ^ {cfg_ff[1].channelInversion,
              cfg_ff[0].channelInversion});  // [RL19]

  assign pinOut = pinOut_ff;
  assign countValue = cnt_ff;
  assign measValue = meas_ff;
  assign channelStatusEvents = evt_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_cfg_reset_zero: assert property ($rose(reset_n) |-> cfg_ff == '0 // [RL21]
    && glob_ff == '0)
    else $error("configuration not zero after reset");
  a_inactive_holds: assert property (!ch[0].active |=> // [RL1]
    cnt_ff[0] == $past(cnt_ff[0]) || $past(ch[0].clr))
    else $error("counter moved while not in classic mode");
  a_rar_never_ref: assert property ( // [RL3]
    cfg_ff[0].resetAtReference && ch[0].stepped && !ch[0].clr
    |=> cnt_ff[0] != $past(refValue[0]))
    else $error("counter reached reference with reset enabled");
  a_dir_down_step: assert property ( // [RL4]
    ch[0].active && !ch[0].dual && ch[0].fn == FN_PULSE
    && cfg_ff[0].countDirection && ch[0].cntEdge && !ch[0].hit1
    |=> cnt_ff[0] == $past(cnt_ff[0]) - 32'h00000001)
    else $error("down count did not decrement");
  a_both_edges: assert property ( // [RL5]
    ch[0].active && !ch[0].dual && ch[0].fn == FN_PULSE
    && cfg_ff[0].edgeSelect && ch[0].aFall && !ch[0].hit1
    |=> cnt_ff[0] != $past(cnt_ff[0]))
    else $error("falling edge not counted with both edges");
  a_dedup_once: assert property ( // [RL2]
    evt_ff[0].ref1Hit && cfg_ff[0].statusEventDedup && !lockReset
    && $stable(cfg_ff[0].statusEventDedup) ##1 !lockReset
    |=> !evt_ff[0].ref1Hit)
    else $error("repeated event despite dedup");
  a_second_ref: assert property ( // [RL6]
    ch[0].hit2 && !(cfg_ff[0].statusEventDedup && lock2_ff)
    |=> evt_ff[0].ref2Hit)
    else $error("second reference equality not flagged");
  a_lock_independent: assert property ( // [RL7]
    lock1_ff[0] && !lock2_ff && ch[0].hit2 |=> evt_ff[0].ref2Hit)
    else $error("first lock suppressed second comparison");
  a_gate_blocks: assert property ( // [RL10]
    ch[0].active && ch[0].dual && ch[0].fn == FN_GATE && !ch[0].bIn
    |=> cnt_ff[0] == $past(cnt_ff[0]))
    else $error("gated counter moved with gate low");
  a_encoder_x4: assert property ( // [RL11]
    ch[0].active && ch[0].dual && ch[0].fn == FN_ENC_X4 && ch[0].bRise
    && !ch[0].aRise && !ch[0].aFall && ch[0].aIn && !ch[0].hit1
    |=> cnt_ff[0] == $past(cnt_ff[0]) + 32'h00000001)
    else $error("quadrature edge on second input missed");
  a_dual_out_same: assert property ( // [RL18]
    glob_ff.dualOutputDrive && !antiOn && $stable(cfg_ff)
    |=> (pinOut[0] ^ pinOut[1]) == $past(cfg_ff[0].channelInversion
        ^ cfg_ff[1].channelInversion))
    else $error("dual drive outputs differ from source");
  a_antivalent_idle: assert property (antiOn && !doLevel[0] // [RL16]
    |=> pinOut[0] == pinOut[1])
    else $error("gated-off outputs not at same level");
  a_output_invert: assert property ( // [RL19]
    !primPwm[1] && !glob_ff.dualOutputDrive && !antiOn
    |=> pinOut[1] == $past(doLevel[1] ^ cfg_ff[1].channelInversion))
    else $error("output inversion not applied");

  c_ref_event: cover property (evt_ff[0].ref1Hit);
  c_second_event: cover property (evt_ff[0].ref2Hit);
  c_encoder_run: cover property (ch[0].dual && ch[0].fn == FN_ENC_X4
    && ch[0].stepped);
  c_period_latch: cover property (ch[0].latch && ch[0].fn == FN_PERIOD);
endmodule

// >>> bench/dcc_field_model.sv
// Field side model: pulse sources and a quadrature encoder on the inputs
`timescale 1ns/1ps
module dcc_field_model (
  input wire logic clk,
  output logic [1:0] pins
);
  logic [1:0] ph;
  initial begin
    pins = 2'h0;
    ph = 2'h0;
  end
  // Edges four clocks apart, above the two-cycle minimum spacing
  task automatic flip(input int ch);
    @(negedge clk);
    pins[ch] = ~pins[ch];
    repeat (3) @(negedge clk);
  endtask
  task automatic enc(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      ph = ph + 2'h1;
      pins = ph ^ (ph >> 1);
      repeat (3) @(negedge clk);
    end
  endtask
  task automatic clear();
    @(negedge clk);
    pins = 2'h0;
    ph = 2'h0;
  endtask
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the two channel counter and PWM unit
`timescale 1ns/1ps
module tb_top;
  import dcc_pkg::*;
  logic clk;
  logic reset_n;
  logic [1:0] pinIn;
  logic [1:0] doLevel;
  dcc_chan_cfg_t [1:0] chanCfg;
  dcc_glob_cfg_t globCfg;
  logic [1:0][CNT_W-1:0] refValue;
  logic [1:0][CNT_W-1:0] pwmDuty;
  logic lockReset;
  logic [1:0] pinOut;
  logic [1:0][CNT_W-1:0] countValue;
  logic [1:0][CNT_W-1:0] measValue;
  dcc_events_t [1:0] chEv;
  int errorCnt;
  int nTests;
  int hit1;
  int hit2;

  dcc_field_model field_u (.clk(clk), .pins(pinIn));
  dcc_counter_pwm #(.ACT_TICKS(4)) dut_u (
    .clk(clk),
    .reset_n(reset_n),
    .pinIn(pinIn),
    .doLevel(doLevel),
    .chanCfg(chanCfg),
    .globCfg(globCfg),
    .refValue(refValue),
    .pwmDuty(pwmDuty),
    .lockReset(lockReset),
    .pinOut(pinOut),
    .countValue(countValue),
    .measValue(measValue),
    .channelStatusEvents(chEv)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Events are one-cycle pulses, so tally them at every edge
  always @(posedge clk) begin
    if (reset_n !== 1'b1) begin
      hit1 <= 0;
      hit2 <= 0;
    end else begin
      hit1 <= hit1 + int'(chEv[0].ref1Hit === 1'b1);
      hit2 <= hit2 + int'(chEv[0].ref2Hit === 1'b1);
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(negedge clk);
    reset_n = 1'b0;
    chanCfg = '0;
    globCfg = '0;
    refValue = '0;
    pwmDuty = '0;
    doLevel = 2'h0;
    lockReset = 1'b0;
    field_u.clear();
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
  endtask

  task automatic pulses(input int ch, input int n);
    repeat (n) begin
      field_u.flip(ch);
      field_u.flip(ch);
    end
  endtask

  task automatic unlock();
    @(negedge clk);
    lockReset = 1'b1;
    @(negedge clk);
    lockReset = 1'b0;
  endtask

  task automatic t_count();
    do_reset();
    pulses(0, 2);
    check("idle count", countValue[0], 32'h0);
    chanCfg[0].primaryFunctionSelect = PRIM_CNT_CLASSIC;
    chanCfg[0].activationPulseEnable = 1'b1;
    chanCfg[0].pulseSpeedSelect = 1'b1;
    pulses(0, 3);
    check("one edge", countValue[0], 32'h3);
    check("no pwm", 32'(pinOut), 32'h0);
    chanCfg[0].edgeSelect = 1'b1;
    pulses(0, 2);
    check("both edges", countValue[0], 32'h7);
    chanCfg[0].edgeSelect = 1'b0;
    chanCfg[0].countDirection = 1'b1;
    pulses(0, 8);
    check("down", countValue[0], 32'hFFFFFFFF);
    // Rising edges eight clocks apart: seven counts between latches
    chanCfg[0].counterFunctionSelect = FN_PERIOD;
    pulses(0, 3);
    check("period", measValue[0], 32'h7);
    $display("test count done");
  endtask

  task automatic t_ref();
    do_reset();
    chanCfg[0].primaryFunctionSelect = PRIM_CNT_CLASSIC;
    chanCfg[0].resetAtReference = 1'b1;
    chanCfg[0].statusEventDedup = 1'b1;
    refValue[0] = 32'h3;
    pulses(0, 2);
    check("below ref", countValue[0], 32'h2);
    pulses(0, 1);
    check("at ref", countValue[0], 32'h0);
    pulses(0, 3);
    check("dedup", 32'(hit1), 32'h1);
    unlock();
    pulses(0, 3);
    check("unlocked", 32'(hit1), 32'h2);
    chanCfg[0].statusEventDedup = 1'b0;
    pulses(0, 6);
    check("no dedup", 32'(hit1), 32'h4);
    $display("test reference done");
  endtask

  task automatic t_ref2();
    do_reset();
    chanCfg[0].primaryFunctionSelect = PRIM_CNT_CLASSIC;
    chanCfg[0].statusEventDedup = 1'b1;
    globCfg.secondReferenceEnable = 1'b1;
    refValue[0] = 32'h2;
    refValue[1] = 32'h4;
    pulses(0, 5);
    check("ref1 hit", 32'(hit1), 32'h1);
    check("ref2 hit", 32'(hit2), 32'h1);
    chanCfg[0].countDirection = 1'b1;
    pulses(0, 3);
    check("both locked", 32'(hit1 + hit2), 32'h2);
    $display("test second reference done");
  endtask

  task automatic t_dual();
    dcc_dual_fn_t fn[3];
    logic [31:0] v;
    fn = '{FN_ENC_X1, FN_ENC_X2, FN_ENC_X4};
    for (int i = 0; i < 3; i++) begin
      do_reset();
      chanCfg[0].primaryFunctionSelect = PRIM_CNT_CLASSIC;
      chanCfg[1].primaryFunctionSelect = PRIM_CNT_CLASSIC;
      chanCfg[0].counterFunctionSelect = fn[i];
      globCfg.dualInputMode = 1'b1;
      field_u.enc(8);
      v = countValue[0];
      check("encoder", 32'(v == 32'(2 << i) || -v == 32'(2 << i)), 1);
      check("counter 2 held", countValue[1], 32'h0);
    end
    chanCfg[0].counterFunctionSelect = FN_DIRSIG;
    field_u.clear();
    pulses(0, 2);
    check("dir count", countValue[0], 32'hA);
    field_u.flip(1);
    pulses(0, 2);
    check("dir back", countValue[0], 32'h8);
    $display("test dual done");
  endtask

  task automatic t_pwm();
    for (int hs = 1; hs >= 0; hs--) begin
      do_reset();
      chanCfg[0].primaryFunctionSelect = PRIM_CNT_PWM;
      chanCfg[0].pulseSpeedSelect = 1'(hs);
      chanCfg[0].activationPulseEnable = 1'b1;
      refValue[0] = 32'h8;
      doLevel = 2'h3;
      repeat (8) @(negedge clk);
      check("act pulse", 32'(pinOut[0]), 32'h1);
      repeat (22) @(negedge clk);
      check("speed", 32'(pinOut[0]), 32'(hs == 0));
    end
    do_reset();
    chanCfg[0].primaryFunctionSelect = PRIM_CNT_PWM;
    chanCfg[0].channelInversion = 1'b1;
    repeat (4) @(negedge clk);
    check("inverted", 32'(pinOut[0]), 32'h1);
    globCfg.antivalentGating = 1'b1;
    globCfg.dualOutputDrive = 1'b1;
    doLevel = 2'h0;
    repeat (4) @(negedge clk);
    check("gated idle", 32'(pinOut), 32'h3);
    doLevel = 2'h1;
    repeat (4) @(negedge clk);
    check("antivalent", 32'(pinOut), 32'h1);
    globCfg.antivalentGating = 1'b0;
    doLevel = 2'h0;
    repeat (4) @(negedge clk);
    check("dual drive", 32'(pinOut), 32'h1);
    $display("test pwm done");
  endtask

  initial begin
    errorCnt = 0;
    nTests = 0;
    reset_n = 1'b0;
    chanCfg = '0;
    globCfg = '0;
    refValue = '0;
    pwmDuty = '0;
    doLevel = 2'h0;
    lockReset = 1'b0;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check("reset outs", 32'(|{pinOut, countValue, chEv}), 0);
    t_count();
    t_ref();
    t_ref2();
    t_dual();
    t_pwm();
    finish_test();
  end

  // Whole run is about six hundred clocks; this leaves a wide margin
  initial begin
    #2000000;
    errorCnt++;
    finish_test();
  end
endmodule
